/* File: rtl/bdt_cfg.svh */
`ifndef BDT_CFG_SVH
`define BDT_CFG_SVH

// Buffer clock rate; every interval below is a whole number of its periods.
`define BDT_CLK_MHZ          125
`define BDT_ADDR_W           11
`define BDT_DATA_W           16
`define BDT_CNT_W            3

`define BDT_CAS_TO_RAS_CYC   5
`define BDT_CAS_HOLD_CYC     4
`define BDT_RAS_HOLD_CYC     1
`define BDT_WE_SETUP_CYC     1
`define BDT_WE_HOLD_CYC      3
`define BDT_WE_WIDTH_CYC     4
`define BDT_REF_LOW_CYC      5
`define BDT_REF_RECOV_CYC    4
`define BDT_REF_ROW_HOLD_CYC 4

// Programmable widths are base + selector value.
`define BDT_RCD_BASE         2
`define BDT_COL_HIGH_BASE    1
`define BDT_COL_LOW_BASE     2

`endif

/* File: rtl/bdt_pkg.sv */
`include "bdt_cfg.svh"
`default_nettype none

package bdt_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ROW_SETUP,
      ST_RCD,
      ST_CAS_LOW,
      ST_PAGE_WAIT,
      ST_CAS_HIGH,
      ST_RAS_HOLD,
      ST_REF_LOW
   } bdt_state_t;

   // One request word; in page mode only col, wdata and last are used.
   typedef struct packed {
      logic                   refresh;
      logic                   write;
      logic                   last;
      logic [`BDT_ADDR_W-1:0] row;
      logic [`BDT_ADDR_W-1:0] col;
      logic [`BDT_DATA_W-1:0] wdata;
   } bdt_req_t;

   typedef struct packed {
      logic       row_to_col_delay_sel;
      logic       col_high_width_sel;
      logic [1:0] col_low_width_sel;
   } bdt_speed_t;

endpackage : bdt_pkg

`default_nettype wire

/* File: rtl/bdt_cycle_timer.sv */
// Behaviour
// - After the column strobe rises, the row strobe falls again no sooner than 5 periods later.
// - The column strobe stays low until at least 4 periods after the row strobe fell.
// - Between page accesses the column strobe is high at least 1 period, or 2 when selected.
// - The column strobe low pulse lasts 2 to 5 periods per the two-bit column-low select.
// - The row strobe stays low at least 1 period after the column strobe rises.
// - On a write, write enable goes low at least 1 period before the column strobe falls.
// - Write enable stays low 3 periods after the column strobe falls and at least 4 in total.
// - The row address is set up 1 period before the row strobe falls and held 1 period after.
// - The column address is set up 1 period before the column fall and held 2 periods after.
// - Write data is set up 1 period before the column fall and held 2 periods after.
// - A refresh holds the row strobe low 5 periods, then high 4 before the next fall.
// - During refresh the row address stays valid 4 periods after the row strobe falls.
`include "bdt_cfg.svh"
`default_nettype none

module bdt_cycle_timer #(
   parameter int ADDR_W = `BDT_ADDR_W,
   parameter int DATA_W = `BDT_DATA_W
) (
   input  wire logic               CLK_I,
   input  wire logic               RESET_I,
   input  wire logic               REQ_VALID_I,
   input  wire bdt_pkg::bdt_req_t  REQ_I,
   input  wire bdt_pkg::bdt_speed_t SPEED_I,
   input  wire logic [DATA_W-1:0]  RD_DATA_I,
   output logic                    REQ_TAKEN_O,
   output logic                    ROW_STROBE_N_O,
   output logic                    COLUMN_STROBE_N_O,
   output logic                    MEM_WRITE_ENABLE_N_O,
   output logic [ADDR_W-1:0]       MEM_ADDR_O,
   output logic [DATA_W-1:0]       MEM_DATA_O,
   output logic                    MEM_DATA_OE_N_O,
   output logic [DATA_W-1:0]       RD_DATA_O,
   output logic                    RD_VALID_O
);

   localparam int CW = `BDT_CNT_W;

   // The request struct fixes the widths, so the parameters may only restate them.
   if (ADDR_W != `BDT_ADDR_W || DATA_W != `BDT_DATA_W) begin : g_bad_width
      $error("bdt_cycle_timer: ADDR_W and DATA_W must match the request struct");
   end

   bdt_pkg::bdt_state_t state_r;
   bdt_pkg::bdt_req_t   req_r;
   logic [CW-1:0]       cnt_r;
   logic [CW-1:0]       recov_r;
   logic [CW-1:0]       wcnt_r;
   logic [CW-1:0]       a_cyc;
   logic [CW-1:0]       b_cyc;
   logic [CW-1:0]       c_cyc;
   logic                take;
   logic                ras_fall;
   logic                col_load;
   logic                cas_fall;
   logic                cas_rise;
   logic                row_end;
   logic                ref_end;

   assign a_cyc = CW'(`BDT_RCD_BASE) + CW'(SPEED_I.row_to_col_delay_sel);
   assign b_cyc = CW'(`BDT_COL_HIGH_BASE) + CW'(SPEED_I.col_high_width_sel);
   assign c_cyc = CW'(`BDT_COL_LOW_BASE) + CW'(SPEED_I.col_low_width_sel);

   assign take     = REQ_VALID_I &&
                     (state_r == bdt_pkg::ST_IDLE || state_r == bdt_pkg::ST_PAGE_WAIT);
   assign ras_fall = (state_r == bdt_pkg::ST_ROW_SETUP) && (recov_r == '0);
   // The column goes out one period after the row strobe falls, so the row stays held.
   assign col_load = (state_r == bdt_pkg::ST_RCD && cnt_r == CW'(1)) ||
                     (state_r == bdt_pkg::ST_PAGE_WAIT && REQ_VALID_I);
   assign cas_fall = (state_r == bdt_pkg::ST_RCD && cnt_r == a_cyc) ||
                     (state_r == bdt_pkg::ST_CAS_HIGH && cnt_r >= b_cyc);
   assign cas_rise = (state_r == bdt_pkg::ST_CAS_LOW) && (cnt_r == c_cyc);
   assign row_end  = (state_r == bdt_pkg::ST_RAS_HOLD) &&
                     (!req_r.write || wcnt_r == CW'(`BDT_WE_HOLD_CYC));
   assign ref_end  = (state_r == bdt_pkg::ST_REF_LOW) &&
                     (cnt_r == CW'(`BDT_REF_LOW_CYC));

   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         state_r <= bdt_pkg::ST_IDLE;
      end else begin
         unique case (state_r)
            bdt_pkg::ST_IDLE: begin
               if (REQ_VALID_I) state_r <= bdt_pkg::ST_ROW_SETUP;
            end
            bdt_pkg::ST_ROW_SETUP: begin
               if (ras_fall) state_r <= req_r.refresh ? bdt_pkg::ST_REF_LOW : bdt_pkg::ST_RCD;
            end
            bdt_pkg::ST_RCD: begin
               if (cas_fall) state_r <= bdt_pkg::ST_CAS_LOW;
            end
            bdt_pkg::ST_CAS_LOW: begin
               if (cas_rise) begin
                  state_r <= req_r.last ? bdt_pkg::ST_RAS_HOLD : bdt_pkg::ST_PAGE_WAIT;
               end
            end
            bdt_pkg::ST_PAGE_WAIT: begin
               if (REQ_VALID_I) state_r <= bdt_pkg::ST_CAS_HIGH;
            end
            bdt_pkg::ST_CAS_HIGH: begin
               if (cas_fall) state_r <= bdt_pkg::ST_CAS_LOW;
            end
            bdt_pkg::ST_RAS_HOLD: begin
               if (row_end) state_r <= bdt_pkg::ST_IDLE;
            end
            bdt_pkg::ST_REF_LOW: begin
               if (ref_end) state_r <= bdt_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Cycles spent since the last row fall or column edge; saturates rather than wraps.
   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         cnt_r <= '0;
      end else if (ras_fall || cas_fall || cas_rise) begin
         cnt_r <= CW'(1);
      end else if (cnt_r != '1) begin
         cnt_r <= cnt_r + CW'(1);
      end
   end

   // Precharge guard, loaded one short because the row fall is itself registered.
   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         recov_r <= '0;
      end else if (cas_rise) begin
         recov_r <= CW'(`BDT_CAS_TO_RAS_CYC - 1);
      end else if (ref_end) begin
         recov_r <= CW'(`BDT_REF_RECOV_CYC - 1);
      end else if (recov_r != '0) begin
         recov_r <= recov_r - CW'(1);
      end
   end

   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         wcnt_r <= '0;
      end else if (cas_fall) begin
         wcnt_r <= CW'(1);
      end else if (wcnt_r < CW'(`BDT_WE_HOLD_CYC)) begin
         wcnt_r <= wcnt_r + CW'(1);
      end
   end

   // Row-level flags stay from the opening request; page words bring only column data.
   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         req_r       <= '0;
         REQ_TAKEN_O <= 1'b0;
      end else begin
         REQ_TAKEN_O <= take;
         if (take && state_r == bdt_pkg::ST_IDLE) begin
            req_r <= REQ_I;
         end else if (take) begin
            req_r.col   <= REQ_I.col;
            req_r.wdata <= REQ_I.wdata;
            req_r.last  <= REQ_I.last;
         end
      end
   end

   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         ROW_STROBE_N_O    <= 1'b1;
         COLUMN_STROBE_N_O <= 1'b1;
      end else begin
         if (ras_fall) ROW_STROBE_N_O <= 1'b0;
         else if (row_end || ref_end) ROW_STROBE_N_O <= 1'b1;
         if (cas_fall) COLUMN_STROBE_N_O <= 1'b0;
         else if (cas_rise) COLUMN_STROBE_N_O <= 1'b1;
      end
   end

   // Address and write data change only at a row open or a column load, which keeps
   // them steady through each strobe's setup and hold windows.
   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         MEM_ADDR_O <= '0;
         MEM_DATA_O <= '0;
      end else if (take && state_r == bdt_pkg::ST_IDLE) begin
         MEM_ADDR_O <= REQ_I.row;
      end else if (col_load) begin
         MEM_ADDR_O <= (state_r == bdt_pkg::ST_PAGE_WAIT) ? REQ_I.col : req_r.col;
         MEM_DATA_O <= (state_r == bdt_pkg::ST_PAGE_WAIT) ? REQ_I.wdata : req_r.wdata;
      end
   end

   // Write enable and the data drive open with the first column and close at row end,
   // so a page write keeps them low across every column.
   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         MEM_WRITE_ENABLE_N_O <= 1'b1;
         MEM_DATA_OE_N_O      <= 1'b1;
      end else if (col_load && req_r.write) begin
         MEM_WRITE_ENABLE_N_O <= 1'b0;
         MEM_DATA_OE_N_O      <= 1'b0;
      end else if (row_end) begin
         MEM_WRITE_ENABLE_N_O <= 1'b1;
         MEM_DATA_OE_N_O      <= 1'b1;
      end
   end

   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         RD_DATA_O  <= '0;
         RD_VALID_O <= 1'b0;
      end else begin
         RD_VALID_O <= cas_rise && !req_r.write;
         if (cas_rise && !req_r.write) RD_DATA_O <= RD_DATA_I;
      end
   end

   // Helper counters for the checks below: periods each strobe has stayed at its level, and write enable has stayed low.
   logic [3:0] ras_lo_q, ras_hi_q, cas_lo_q, cas_hi_q, we_lo_q;

   function automatic logic [3:0] sat_inc(input logic [3:0] v);
      return (v == 4'hf) ? v : v + 4'h1;
   endfunction : sat_inc

   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         ras_lo_q <= 4'h0;
         ras_hi_q <= 4'hf;
         cas_lo_q <= 4'h0;
         cas_hi_q <= 4'hf;
         we_lo_q  <= 4'h0;
      end else begin
         ras_lo_q <= ROW_STROBE_N_O ? 4'h0 : sat_inc(ras_lo_q);
         ras_hi_q <= ROW_STROBE_N_O ? sat_inc(ras_hi_q) : 4'h0;
         cas_lo_q <= COLUMN_STROBE_N_O ? 4'h0 : sat_inc(cas_lo_q);
         cas_hi_q <= COLUMN_STROBE_N_O ? sat_inc(cas_hi_q) : 4'h0;
         we_lo_q  <= MEM_WRITE_ENABLE_N_O ? 4'h0 : sat_inc(we_lo_q);
      end
   end

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RESET_I);

   a_ras_after_cas: assert property ($fell(ROW_STROBE_N_O) |-> cas_hi_q >= 4'h5)
      else $error("row strobe fell too soon after column strobe rose");
   a_row_col_delay: assert property ($fell(COLUMN_STROBE_N_O) && ras_lo_q <= 4'h3 |->
      ras_lo_q == 4'h2 + 4'(SPEED_I.row_to_col_delay_sel))
      else $error("row to column delay wrong");
   a_cas_hold_ras: assert property ($rose(COLUMN_STROBE_N_O) |-> ras_lo_q >= 4'h4)
      else $error("column strobe released too early after row fall");
   a_cas_high_width: assert property ($fell(COLUMN_STROBE_N_O) |->
      cas_hi_q >= 4'h1 + 4'(SPEED_I.col_high_width_sel))
      else $error("column strobe high too short");
   a_cas_low_width: assert property ($rose(COLUMN_STROBE_N_O) |->
      cas_lo_q == 4'h2 + 4'(SPEED_I.col_low_width_sel))
      else $error("column strobe low width wrong");
   a_ras_hold_cas: assert property ($rose(ROW_STROBE_N_O) && !req_r.refresh |->
      cas_hi_q >= 4'h1)
      else $error("row strobe rose without column hold");
   a_we_setup: assert property ($fell(COLUMN_STROBE_N_O) && req_r.write |->
      we_lo_q >= 4'h1)
      else $error("write enable not set up before column fall");
   a_we_hold: assert property ($fell(COLUMN_STROBE_N_O) && req_r.write |->
      !MEM_WRITE_ENABLE_N_O [*3])
      else $error("write enable released too soon after column fall");
   a_we_width: assert property ($rose(MEM_WRITE_ENABLE_N_O) |-> we_lo_q >= 4'h4)
      else $error("write enable pulse too narrow");
   a_row_addr_hold: assert property ($fell(ROW_STROBE_N_O) |-> $stable(MEM_ADDR_O))
      else $error("row address moved around row fall");
   a_col_addr_hold: assert property ($fell(COLUMN_STROBE_N_O) |->
      $stable(MEM_ADDR_O) ##1 $stable(MEM_ADDR_O))
      else $error("column address moved around column fall");
   a_wdata_hold: assert property ($fell(COLUMN_STROBE_N_O) && req_r.write |->
      ($stable(MEM_DATA_O) && !MEM_DATA_OE_N_O) [*2])
      else $error("write data moved around column fall");
   a_ref_ras_low: assert property ($rose(ROW_STROBE_N_O) && req_r.refresh |->
      ras_lo_q >= 4'h5)
      else $error("refresh row strobe too short");
   a_ras_recovery: assert property ($fell(ROW_STROBE_N_O) |-> ras_hi_q >= 4'h4)
      else $error("row strobe recovery too short");
   a_ref_addr_hold: assert property ($fell(ROW_STROBE_N_O) && req_r.refresh |->
      $stable(MEM_ADDR_O) [*5])
      else $error("refresh row address moved too soon");
   a_page_row_open: assert property ($rose(COLUMN_STROBE_N_O) && !req_r.last |->
      !ROW_STROBE_N_O ##1 !ROW_STROBE_N_O)
      else $error("row strobe dropped inside a page");

   c_refresh_done: cover property (req_r.refresh && $rose(ROW_STROBE_N_O));
   c_page_column:  cover property ($fell(COLUMN_STROBE_N_O) && ras_lo_q > 4'h3);
   c_write_row:    cover property ($rose(MEM_WRITE_ENABLE_N_O));
   c_read_data:    cover property (RD_VALID_O);

endmodule : bdt_cycle_timer

`default_nettype wire

/* File: verification/bdt_dram_model.sv */
`default_nettype none

module bdt_dram_model (
   input  wire logic        clk_i,
   input  wire logic        row_n_i,
   input  wire logic        col_n_i,
   input  wire logic        we_n_i,
   input  wire logic [10:0] addr_i,
   input  wire logic [15:0] data_i,
   output logic      [15:0] rd_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [15:0] mem [int];
   logic [10:0] row_r;
   logic        row_p = 1'b1;
   logic        col_p = 1'b1;

   initial rd_o = 16'h0000;

   // Read data turns up one cycle after the column fall, the latest that still meets the
   // shortest low pulse; a released bus toggles so a stale capture cannot pass by luck.
   always @(posedge clk_i) begin
      row_p <= row_n_i;
      col_p <= col_n_i;
      if (!row_n_i && row_p)
         row_r <= addr_i;
      if (!col_n_i && col_p) begin
         if (!we_n_i)
            mem[{row_r, addr_i}] = data_i;
         else
            rd_o <= mem.exists({row_r, addr_i}) ? mem[{row_r, addr_i}] : 16'h0000;
      end else if (col_n_i) begin
         rd_o <= ~rd_o;
      end
   end
endmodule : bdt_dram_model

`default_nettype wire

/* File: verification/bdt_cycle_timer_test.sv */
`default_nettype none

module bdt_cycle_timer_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic                clk, rst, req_valid, req_taken, row_n, col_n, we_n, oe_n, rd_valid;
   bdt_pkg::bdt_req_t   req;
   bdt_pkg::bdt_speed_t speed;
   logic [10:0]         addr, cbase, row, cur_row, cur_col, pa;
   logic [15:0]         mdata, rd_in, rd_out, cur_wd, pd;
   logic [31:0]         seed = 32'h08ab3450;
   logic [1:0]          cur_k, last_k;
   logic                pr = 1'b1, pc = 1'b1, pw = 1'b1;
   int                  failures, check_count, cyc, ncol, cur_n, n;
   int                  t_rf = -99, t_rr = -99, t_cf = -99, t_cr = -99, t_wf = -99;
   logic [15:0]         bmem [int];
   logic [10:0]         rowq [$], colq [$];
   logic [15:0]         wdq [$], rdq [$];
   logic [1:0]          kq [$];
   int                  nq [$];

   bdt_cycle_timer DUT (.CLK_I(clk), .RESET_I(rst), .REQ_VALID_I(req_valid), .REQ_I(req),
      .SPEED_I(speed), .RD_DATA_I(rd_in), .REQ_TAKEN_O(req_taken), .ROW_STROBE_N_O(row_n),
      .COLUMN_STROBE_N_O(col_n), .MEM_WRITE_ENABLE_N_O(we_n), .MEM_ADDR_O(addr),
      .MEM_DATA_O(mdata), .MEM_DATA_OE_N_O(oe_n), .RD_DATA_O(rd_out), .RD_VALID_O(rd_valid));

   bdt_dram_model dram (.clk_i(clk), .row_n_i(row_n), .col_n_i(col_n), .we_n_i(we_n),
      .addr_i(addr), .data_i(mdata), .rd_o(rd_in));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %0t %s: seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask : chk

   task automatic stop_test();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test

   // Each sample sees the values held during the cycle that just ended.
   always @(posedge clk) begin
      cyc++;
      if (!rst) begin
         if (pr && !row_n) begin
            cur_row = rowq.pop_front();
            cur_k = kq.pop_front();
            cur_n = nq.pop_front();
            chk(cyc - t_cr >= 5, 1, "column rise to row fall");
            if (last_k[1]) chk(cyc - t_rr >= 4, 1, "refresh recovery");
            chk(pa, cur_row, "row setup");
            t_rf = cyc;
            ncol = 0;
         end
         if (!row_n && cyc - t_rf <= (cur_k[1] ? 3 : 0)) chk(addr, cur_row, "row hold");
         if (pc && !col_n) begin
            cur_col = colq.pop_front();
            if (cur_k[0]) cur_wd = wdq.pop_front();
            if (ncol == 0) chk(cyc - t_rf, 2 + speed.row_to_col_delay_sel, "row to col");
            else chk(cyc - t_cr >= 1 + speed.col_high_width_sel, 1, "col high");
            chk(pa, cur_col, "col setup");
            if (cur_k[0]) chk({pw, pd}, {1'b0, cur_wd}, "write setup");
            t_cf = cyc;
            ncol++;
         end
         if (!col_n && cyc - t_cf <= 1) chk(addr, cur_col, "col hold");
         if (!col_n && cur_k[0] && cyc - t_cf <= 1)
            chk({we_n, oe_n, mdata}, {2'b00, cur_wd}, "data hold");
         if (!pc && col_n) begin
            chk(cyc - t_cf, 2 + speed.col_low_width_sel, "col low");
            if (ncol == 1) chk(cyc - t_rf >= 4, 1, "col after row");
            t_cr = cyc;
         end
         if (!pr && row_n) begin
            if (cur_k[1]) chk(cyc - t_rf >= 5, 1, "refresh low");
            else chk(cyc - t_cr >= 1, 1, "row after col");
            if (!cur_k[1]) chk(ncol, cur_n, "page count");
            t_rr = cyc;
            last_k = cur_k;
         end
         if (!pw && we_n) chk(cyc - t_wf >= 4 && cyc - t_cf >= 3, 1, "we width");
         if (pw && !we_n) t_wf = cyc;
         if (rd_valid === 1'b1) chk(rd_out, rdq.pop_front(), "read data");
      end
      pr = row_n;
      pc = col_n;
      pw = we_n;
      pa = addr;
      pd = mdata;
   end

   // Kind: bit 1 refresh, bit 0 write. Columns of a page are spaced from cbase.
   task automatic send(input logic [1:0] k, input int cnt, input logic [10:0] r);
      logic [10:0] col;
      logic [15:0] wd;
      int          w;
      rowq.push_back(r);
      kq.push_back(k);
      nq.push_back(cnt);
      for (int i = 0; i < cnt; i++) begin
         col = cbase + 11'(3 * i);
         wd = 16'(rnd());
         req = '{k[1], k[0], i == cnt - 1, r, col, wd};
         if (!k[1]) colq.push_back(col);
         if (k == 2'b01) wdq.push_back(wd);
         if (k == 2'b01) bmem[{r, col}] = wd;
         if (k == 2'b00) rdq.push_back(bmem[{r, col}]);
         req_valid = 1'b1;
         w = 0;
         do begin
            @(posedge clk);
            #1;
            w++;
         end while (req_taken !== 1'b1 && w < 60);
         chk(w < 60, 1, "request taken");
         if (i == cnt - 1 || rnd() % 2 == 0) begin
            req_valid = 1'b0;
            repeat (1 + rnd() % 3) @(posedge clk);
            #1;
         end
      end
   endtask : send

   // A read may still wait for precharge with the row strobe high, so the speed must not
   // change until every expected read word has come back and the row has closed.
   task automatic settle();
      int w = 0;
      do begin
         @(posedge clk);
         #1;
         w++;
      end while ((row_n !== 1'b1 || rdq.size() != 0) && w < 40);
      chk(w < 40, 1, "row closed");
   endtask : settle

   initial begin
      rst = 1'b1;
      req_valid = 1'b0;
      req = '0;
      speed = '0;
      repeat (12) @(posedge clk);
      #1;
      rst = 1'b0;
      chk({row_n, col_n, we_n, oe_n, rd_valid}, 5'h1e, "idle after reset");
      // Every speed setting in turn; write, refresh and read follow back to back.
      for (int s = 0; s < 16; s++) begin
         speed = bdt_pkg::bdt_speed_t'(4'(s));
         cbase = 11'(rnd());
         row = 11'(rnd());
         n = (s == 0) ? 1 : (s == 15) ? 8 : 1 + rnd() % 4;
         send(2'b01, n, row);
         send(2'b10, 1, 11'(rnd()));
         send(2'b00, n, row);
         settle();
         $display("test speed %0d done, pages of %0d, failures %0d", s, n, failures);
      end
      settle();
      chk(rdq.size(), 0, "reads outstanding");
      stop_test();
   end

   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      $display("BAD %0t watchdog expired", $time);
      stop_test();
   end
endmodule : bdt_cycle_timer_test

`default_nettype wire
